// ### hw/nvm_port_defs.svh
// constants of the parallel programming port
`ifndef NVM_PORT_DEFS_SVH
`define NVM_PORT_DEFS_SVH

// action select codes taken on a load strobe
`define ACT_ADDR     2'b00
`define ACT_DATA     2'b01
`define ACT_CMD      2'b10

// command bytes
`define CMD_NOP      8'h00
`define CMD_ERASE    8'h80
`define CMD_WFUSE    8'h40
`define CMD_WLOCK    8'h20
`define CMD_WFLASH   8'h10
`define CMD_WEEP     8'h11
`define CMD_RFUSE    8'h04
`define CMD_RFLASH   8'h02
`define CMD_REEP     8'h03

// timing, clock period and derived cycle counts
`define CLK_NS       50
`define T_ENTRY_NS   100
`define ENTRY_CYC    (`T_ENTRY_NS / `CLK_NS)
`define T_WR_US      1500
`define T_CE_US      23000
`define T_FLASH_US   12000
`define US_TO_CYC(t) (((t) * 1000) / `CLK_NS)

// array geometry
`define FLASH_AW     13
`define PAGE_AW      6
`define EEP_AW       9
`define PAGE_WORDS   64
`define FLASH_WORDS  8192
`define EEP_BYTES    512
`define FIFO_DEPTH   32
`define FIFO_W       15

// field positions
`define AHI_FLASH    4:0
`define AHI_EEP      0
`define ALO_PAGE     7:6
`define ALO_WORD     5:0
`define LOCK_BITS    5:0
`define LOCK_LB1     0

// erased and reset values
`define ERASED_WORD  16'hffff
`define ERASED_BYTE  8'hff
`define LOCK_CLEAR   6'h3f
`define FUSE_LO_RST  8'hd2
`define FUSE_HI_RST  8'hff
`define RSV_HI       2'b11
`define TMR_W        20

`endif

// ### hw/nvm_port_pkg.sv
// types shared by the programming port
package nvm_port_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_PAGE  = 4'b0100,
    ST_BYTE  = 4'b1000
  } state_e;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
endpackage

// ### hw/latch_fifo.sv
// fifo with registered output stage for page-latch entries
`timescale 1ns/10ps
module latch_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // ===========================================================
  // flow control
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign push       = in_valid_i & in_ready_o;
  assign pop        = (count != '0) & (~out_valid_o | out_ready_i);

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // registered output stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

// ### hw/nvm_prog_port.sv
// parallel programming port: command, address, page buffer, arrays
// Behaviour
// - load strobe, code 00/01: address/data byte, byte select picks half
// - code 10 loads the data bus as command; code 11 ignored
// - erase command and write pulse clear flash, eeprom, locks; fuses kept
// - lock bits stay programmed until all program memory is erased
// - write pulse starts operation, flag busy until done; wait for ready
// - flash is 128 pages of 128 bytes, written a whole page at once
// - page latch pulse copies loaded byte into buffer, half by byte select
// - page number is five high-address bits over low-address bits 7 and 6
// - write flash command and write pulse program the buffered page
// - no-operation command ends page programming, resetting write state
// - write eeprom: each write pulse with byte select 1 low programs loaded byte at loaded address
// - command and address are kept across several accesses
// - read flash drives low or high word byte by byte select
// - read eeprom drives the addressed byte when enabled
// - low fuse write: low fuse byte, zero programs a bit
// - byte select high during write sets the high fuse bits
// - write lock maps data bits 5..0 onto lock bits, zero programs
// - only chip erase or reset returns lock bits to unprogrammed
// - byte select 1 activity shortly after high voltage blocks mode entry
// - ready flag low while busy, high when a command may follow
// - data bus driven only while output enable is low
`timescale 1ns/10ps
`include "nvm_port_defs.svh"
module nvm_prog_port #(
  parameter int WR_CYC    = `US_TO_CYC(`T_WR_US),
  parameter int ERASE_CYC = `US_TO_CYC(`T_CE_US),
  parameter int FLASH_CYC = `US_TO_CYC(`T_FLASH_US)
) (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  input  wire logic               high_voltage_i,
  input  wire logic               load_strobe_i,
  input  wire logic               action_select_hi_i,
  input  wire logic               action_select_lo_i,
  input  wire logic               byte_select_one_i,
  input  wire logic               byte_select_two_i,
  input  wire logic               page_latch_strobe_i,
  input  wire logic               write_n_i,
  input  wire logic               output_enable_n_i,
  input  wire nvm_port_pkg::byte_t data_i,
  output nvm_port_pkg::byte_t     data_o,
  output logic                    data_oe_n_o,
  output logic                    ready_busy_flag_o,
  output logic                    prog_mode_o,
  output nvm_port_pkg::byte_t     low_fuses_o,
  output nvm_port_pkg::byte_t     high_fuses_o,
  output logic [5:0]              lock_bits_o
);
  import nvm_port_pkg::*;

  state_e              state;
  logic                load_q;
  logic                latch_q;
  logic                wr_q;
  logic                hv_q;
  logic                bs1_q;
  logic [1:0]          entry_cnt;
  logic                entry_fail;
  byte_t               cmd;
  byte_t               addr_lo;
  byte_t               addr_hi;
  byte_t               data_lo;
  byte_t               data_hi;
  logic [`TMR_W-1:0]   timer;
  logic [`FLASH_AW:0]  walk;
  logic                walk_done;
  logic                load_ev;
  logic                latch_ev;
  logic                wr_ev;
  logic [1:0]          action;
  logic [6:0]          page;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [`FIFO_W-1:0]  fifo_out;
  word_t               flash   [`FLASH_WORDS];
  word_t               pagebuf [`PAGE_WORDS];
  byte_t               eeprom  [`EEP_BYTES];

  // word and byte address helpers
  function automatic logic [`FLASH_AW-1:0] flash_word(input byte_t hi,
                                                       input byte_t lo);
    flash_word = {hi[`AHI_FLASH], lo};
  endfunction

  function automatic logic [`EEP_AW-1:0] eep_byte(input byte_t hi,
                                                   input byte_t lo);
    eep_byte = {hi[`AHI_EEP], lo};
  endfunction

  // ===========================================================
  // strobe edge detection
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_q  <= 1'b0;
      latch_q <= 1'b0;
      wr_q    <= 1'b1;
      hv_q    <= 1'b0;
      bs1_q   <= 1'b0;
    end else begin
      load_q  <= load_strobe_i;
      latch_q <= page_latch_strobe_i;
      wr_q    <= write_n_i;
      hv_q    <= high_voltage_i;
      bs1_q   <= byte_select_one_i;
    end
  end

  assign load_ev  = load_strobe_i & ~load_q & prog_mode_o;
  assign latch_ev = page_latch_strobe_i & ~latch_q & prog_mode_o;
  assign wr_ev    = ~write_n_i & wr_q & prog_mode_o & (state == ST_IDLE);
  assign action   = {action_select_hi_i, action_select_lo_i};
  assign page     = {addr_hi[`AHI_FLASH], addr_lo[`ALO_PAGE]};

  // ===========================================================
  // programming mode entry with byte select 1 guard window
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_mode_o <= 1'b0;
      entry_cnt   <= '0;
      entry_fail  <= 1'b0;
    end else if (!high_voltage_i) begin
      prog_mode_o <= 1'b0;
      entry_cnt   <= '0;
      entry_fail  <= 1'b0;
    end else if (!hv_q) begin
      entry_cnt  <= 2'(`ENTRY_CYC);
      entry_fail <= byte_select_one_i | byte_select_two_i;
    end else if (entry_cnt != '0) begin
      entry_cnt <= entry_cnt - 1'b1;
      if (byte_select_one_i != bs1_q) begin
        entry_fail <= 1'b1;
      end
      if (entry_cnt == 2'd1) begin
        prog_mode_o <= ~entry_fail & (byte_select_one_i == bs1_q);
      end
    end
  end

  // ===========================================================
  // command, address and data byte registers, kept until reloaded
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd     <= `CMD_NOP;
      addr_lo <= '0;
      addr_hi <= '0;
      data_lo <= '0;
      data_hi <= '0;
    end else if (load_ev) begin
      case (action)
        `ACT_ADDR: begin
          if (byte_select_one_i) begin
            addr_hi <= data_i;
          end else begin
            addr_lo <= data_i;
          end
        end
        `ACT_DATA: begin
          if (byte_select_one_i) begin
            data_hi <= data_i;
          end else begin
            data_lo <= data_i;
          end
        end
        `ACT_CMD: cmd <= data_i;
        default: ;
      endcase
    end
  end

  // ===========================================================
  // page latch entries queue: {high half, word index, byte}
  latch_fifo #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_latch_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (latch_ev),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({byte_select_one_i, addr_lo[`ALO_WORD],
                   byte_select_one_i ? data_hi : data_lo}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out)
  );

  // queue entries only drain into the buffer while the sequencer is idle
  assign fifo_out_ready = (state == ST_IDLE);

  // page buffer fill, wiped by the no-operation command
  always_ff @(posedge clk_i) begin
    if (load_ev && action == `ACT_CMD && data_i == `CMD_NOP) begin
      for (int i = 0; i < `PAGE_WORDS; i++) begin
        pagebuf[i] <= `ERASED_WORD;
      end
    end else if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out[14]) begin
        pagebuf[fifo_out[13:8]][15:8] <= fifo_out[7:0];
      end else begin
        pagebuf[fifo_out[13:8]][7:0]  <= fifo_out[7:0];
      end
    end
  end

  // ===========================================================
  // operation sequencer and busy timer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      timer <= '0;
      walk  <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          walk <= '0;
          if (wr_ev) begin
            case (cmd)
              `CMD_ERASE: begin
                state <= ST_ERASE;
                timer <= `TMR_W'(ERASE_CYC);
              end
              `CMD_WFLASH: begin
                state <= ST_PAGE;
                timer <= `TMR_W'(FLASH_CYC);
              end
              `CMD_WEEP, `CMD_WFUSE, `CMD_WLOCK: begin
                state <= ST_BYTE;
                timer <= `TMR_W'(WR_CYC);
              end
              default: ;
            endcase
          end
        end
        ST_ERASE, ST_PAGE: begin
          if (!walk_done) begin
            walk <= walk + 1'b1;
          end
          if (timer > `TMR_W'(1)) begin
            timer <= timer - 1'b1;
          end else if (walk_done) begin
            state <= ST_IDLE;
          end
        end
        ST_BYTE: begin
          if (timer > `TMR_W'(1)) begin
            timer <= timer - 1'b1;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign walk_done = (state == ST_PAGE) ? (walk == `PAGE_WORDS)
                                        : (walk == `FLASH_WORDS);

  // busy also while the latch queue is full, stalling the programmer
  assign ready_busy_flag_o = (state == ST_IDLE) & fifo_in_ready;

  // ===========================================================
  // flash array: page copy or erase walk
  always_ff @(posedge clk_i) begin
    if (state == ST_ERASE && !walk_done) begin
      flash[walk[`FLASH_AW-1:0]] <= `ERASED_WORD;
    end else if (state == ST_PAGE && !walk_done) begin
      flash[{page, walk[`PAGE_AW-1:0]}] <=
        pagebuf[walk[`PAGE_AW-1:0]];
    end
  end

  // eeprom array: single byte write or erase walk
  always_ff @(posedge clk_i) begin
    if (state == ST_ERASE && !walk[`FLASH_AW] &&
        walk[`FLASH_AW-1:0] < `EEP_BYTES) begin
      eeprom[walk[`EEP_AW-1:0]] <= `ERASED_BYTE;
    end else if (wr_ev && cmd == `CMD_WEEP && !byte_select_one_i) begin
      eeprom[eep_byte(addr_hi, addr_lo)] <= data_lo;
    end
  end

  // ===========================================================
  // fuse and lock bits; fuses untouched by chip erase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_fuses_o  <= `FUSE_LO_RST;
      high_fuses_o <= `FUSE_HI_RST;
      lock_bits_o  <= `LOCK_CLEAR;
    end else begin
      if (state == ST_ERASE && walk_done && timer <= `TMR_W'(1)) begin
        lock_bits_o <= `LOCK_CLEAR;
      end else if (wr_ev && cmd == `CMD_WLOCK) begin
        lock_bits_o <= lock_bits_o & data_lo[`LOCK_BITS];
      end
      if (wr_ev && cmd == `CMD_WFUSE && lock_bits_o[`LOCK_LB1]) begin
        if (byte_select_one_i) begin
          high_fuses_o <= data_lo;
        end else begin
          low_fuses_o <= data_lo;
        end
      end
    end
  end

  // ===========================================================
  // read data register and bus drive
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= '0;
    end else begin
      case (cmd)
        `CMD_RFLASH: data_o <= byte_select_one_i
          ? flash[flash_word(addr_hi, addr_lo)][15:8]
          : flash[flash_word(addr_hi, addr_lo)][7:0];
        `CMD_REEP:   data_o <= eeprom[eep_byte(addr_hi, addr_lo)];
        `CMD_RFUSE: begin
          if (byte_select_two_i) begin
            data_o <= high_fuses_o;
          end else if (byte_select_one_i) begin
            data_o <= {`RSV_HI, lock_bits_o};
          end else begin
            data_o <= low_fuses_o;
          end
        end
        default: data_o <= `ERASED_BYTE;
      endcase
    end
  end

  assign data_oe_n_o = output_enable_n_i | ~prog_mode_o;
endmodule

// ### sim/nvm_port_monitor.sv
// concurrent checks on the programming port pins
`timescale 1ns/10ps
`include "nvm_port_defs.svh"
module nvm_port_monitor #(
  parameter int ERASE_CYC = 4,
  parameter int FLASH_CYC = 4
) (
  input wire logic                clk_i,
  input wire logic                rstn_i,
  input wire logic                high_voltage_i,
  input wire logic                load_strobe_i,
  input wire logic                action_select_hi_i,
  input wire logic                action_select_lo_i,
  input wire logic                byte_select_one_i,
  input wire logic                byte_select_two_i,
  input wire logic                write_n_i,
  input wire logic                output_enable_n_i,
  input wire nvm_port_pkg::byte_t data_i,
  input wire logic                data_oe_n_o,
  input wire logic                ready_busy_flag_o,
  input wire logic                prog_mode_o,
  input wire nvm_port_pkg::byte_t low_fuses_o,
  input wire nvm_port_pkg::byte_t high_fuses_o,
  input wire logic [5:0]          lock_bits_o
);
  import nvm_port_pkg::*;
  // ==========================================================
  // helper state
  byte_t cmd;
  logic  ld_q;
  int    busy_cnt;
  // command as seen on the pins, busy run length
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd      <= 8'h00;
      ld_q     <= 1'b0;
      busy_cnt <= 0;
    end else begin
      ld_q     <= load_strobe_i;
      busy_cnt <= ready_busy_flag_o ? 0 : busy_cnt + 1;
      if (load_strobe_i && !ld_q && prog_mode_o &&
          {action_select_hi_i, action_select_lo_i} == `ACT_CMD) begin
        cmd <= data_i;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // assertions
  sequence s_entry;
    !high_voltage_i ##1 (high_voltage_i && !byte_select_one_i &&
    !byte_select_two_i) ##1 (high_voltage_i && !byte_select_one_i)[*2];
  endsequence
  sequence s_take_write;
    prog_mode_o && ready_busy_flag_o && $fell(write_n_i);
  endsequence
  a_mode_entry: assert property (s_entry |-> ##1 prog_mode_o)
    else $error("mode entry missed");
  a_entry_block: assert property ((!prog_mode_o && !high_voltage_i)
    ##1 high_voltage_i ##1 $changed(byte_select_one_i) |-> !prog_mode_o[*3])
    else $error("entry not blocked");
  a_eep_busy: assert property (s_take_write ##0
    (cmd == `CMD_WEEP) |-> ##1 !ready_busy_flag_o[*3]
    ##[1:40] ready_busy_flag_o)
    else $error("eeprom busy wrong");
  a_page_busy: assert property (($rose(ready_busy_flag_o) &&
    cmd == `CMD_WFLASH) |-> busy_cnt >= 64)
    else $error("page write too short");
  a_erase_walk: assert property (($rose(ready_busy_flag_o) &&
    cmd == `CMD_ERASE) |-> busy_cnt >= 8192)
    else $error("erase too short");
  a_busy_bounded: assert property
    (busy_cnt < ERASE_CYC + FLASH_CYC + 9000)
    else $error("busy never ends");
  a_lock_release: assert property
    ((lock_bits_o & ~$past(lock_bits_o)) != 6'h00 |->
    cmd == `CMD_ERASE && busy_cnt >= 8191)
    else $error("lock bits cleared early");
  a_fuse_keep: assert property (cmd == `CMD_ERASE |->
    $stable(low_fuses_o) && $stable(high_fuses_o))
    else $error("fuses changed by erase");
  a_bus_drive: assert property
    (data_oe_n_o == (output_enable_n_i || !prog_mode_o))
    else $error("bus drive wrong");
endmodule
bind nvm_prog_port nvm_port_monitor #(
  .ERASE_CYC(ERASE_CYC), .FLASH_CYC(FLASH_CYC)
) u_nvm_port_monitor (
  .clk_i(clk_i), .rstn_i(rstn_i), .high_voltage_i(high_voltage_i),
  .load_strobe_i(load_strobe_i), .action_select_hi_i(action_select_hi_i),
  .action_select_lo_i(action_select_lo_i),
  .byte_select_one_i(byte_select_one_i),
  .byte_select_two_i(byte_select_two_i), .write_n_i(write_n_i),
  .output_enable_n_i(output_enable_n_i), .data_i(data_i),
  .data_oe_n_o(data_oe_n_o), .ready_busy_flag_o(ready_busy_flag_o),
  .prog_mode_o(prog_mode_o), .low_fuses_o(low_fuses_o),
  .high_fuses_o(high_fuses_o), .lock_bits_o(lock_bits_o)
);

// ### sim/nvm_programmer.sv
// behavioural parallel programmer driving the port pins
`timescale 1ns/10ps
module nvm_programmer (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_i,
  output logic            high_voltage_o,
  output logic            load_strobe_o,
  output logic [1:0]      action_o,
  output logic            sel_one_o,
  output logic            sel_two_o,
  output logic            page_latch_o,
  output logic            write_n_o,
  output logic            out_en_n_o,
  output logic [7:0]      drive_o
);
  // ==========================================================
  // idle levels
  initial begin
    {high_voltage_o, load_strobe_o, page_latch_o, sel_one_o} = 4'h0;
    {action_o, sel_two_o, drive_o} = 11'h000;
    {write_n_o, out_en_n_o} = 2'b11;
  end
  // high voltage rise, optional select jolt inside the window
  task automatic enter(input logic jolt);
    @(posedge clk_i);
    high_voltage_o <= 1'b0;
    sel_one_o      <= 1'b0;
    repeat (2) @(posedge clk_i);
    high_voltage_o <= 1'b1;
    @(posedge clk_i);
    sel_one_o <= jolt;
    repeat (4) @(posedge clk_i);
    sel_one_o <= 1'b0;
  endtask
  // one positive load pulse with code and byte
  task automatic load(input logic [1:0] act, input logic sel,
                      input logic [7:0] val);
    @(posedge clk_i);
    action_o      <= act;
    sel_one_o     <= sel;
    drive_o       <= val;
    load_strobe_o <= 1'b1;
    @(posedge clk_i);
    load_strobe_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // page latch pulse for the chosen half
  task automatic latch(input logic sel);
    @(posedge clk_i);
    sel_one_o    <= sel;
    page_latch_o <= 1'b1;
    @(posedge clk_i);
    page_latch_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // negative write pulse
  task automatic write(input logic sel);
    @(posedge clk_i);
    sel_one_o <= sel;
    write_n_o <= 1'b0;
    @(posedge clk_i);
    write_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
  // output enable low, bus released with a changed level
  task automatic read(input logic sel, input logic two,
                      output logic [7:0] val);
    @(posedge clk_i);
    sel_one_o  <= sel;
    sel_two_o  <= two;
    out_en_n_o <= 1'b0;
    drive_o    <= ~drive_o;
    repeat (3) @(posedge clk_i);
    val = bus_i;
    out_en_n_o <= 1'b1;
    sel_two_o  <= 1'b0;
  endtask
endmodule

// ### sim/testbench.sv
// self-checking bench for the parallel programming port
`timescale 1ns/10ps
`include "nvm_port_defs.svh"
module testbench;
  import nvm_port_pkg::*;
  typedef struct packed { byte_t ahi; byte_t alo; byte_t val; } row_s;
  // ==========================================================
  // signals and rows
  logic       clk_i, rstn_i, hv, ld, sone, stwo, pl, wn, oen, oe_n, rdy, pm;
  logic [1:0] act;
  logic [5:0] lock;
  byte_t      drive, bus, dout, lfuse, hfuse, rd;
  int         errors, n_compared;
  localparam int FAST_CYC = 4; // short busy times keep the run brief
  row_s rows [4] = '{'{8'h00, 8'h00, 8'h3c}, '{8'h00, 8'hff, 8'ha5},
                     '{8'h01, 8'h00, 8'h5a}, '{8'h01, 8'hff, 8'hc3}};
  assign bus = oe_n ? drive : dout; // wire level of the shared bus
  nvm_prog_port #(.WR_CYC(FAST_CYC), .ERASE_CYC(FAST_CYC),
    .FLASH_CYC(FAST_CYC)) u_nvm_prog_port (
    .clk_i(clk_i), .rstn_i(rstn_i), .high_voltage_i(hv), .load_strobe_i(ld),
    .action_select_hi_i(act[1]), .action_select_lo_i(act[0]),
    .byte_select_one_i(sone), .byte_select_two_i(stwo),
    .page_latch_strobe_i(pl), .write_n_i(wn), .output_enable_n_i(oen),
    .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n), .ready_busy_flag_o(rdy),
    .prog_mode_o(pm), .low_fuses_o(lfuse), .high_fuses_o(hfuse),
    .lock_bits_o(lock));
  nvm_programmer u_nvm_programmer (
    .clk_i(clk_i), .bus_i(bus), .high_voltage_o(hv), .load_strobe_o(ld),
    .action_o(act), .sel_one_o(sone), .sel_two_o(stwo), .page_latch_o(pl),
    .write_n_o(wn), .out_en_n_o(oen), .drive_o(drive));
  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ==========================================================
  // tasks
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_i);
    while (rdy !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      check("ready wait", 1'b1, rdy);
      final_report();
    end
  endtask
  task automatic ld_b(input logic [1:0] a, input logic s, input byte_t v);
    u_nvm_programmer.load(a, s, v);
  endtask
  task automatic cmd(input byte_t v);
    ld_b(`ACT_CMD, 1'b0, v);
  endtask
  task automatic addr(input byte_t hi, input byte_t lo);
    ld_b(`ACT_ADDR, 1'b1, hi);
    ld_b(`ACT_ADDR, 1'b0, lo);
  endtask
  task automatic wr(input logic s);
    u_nvm_programmer.write(s);
    check("busy flag", 1'b0, rdy);
    wait_ready();
  endtask
  task automatic rd_chk(input string w, input logic s, input logic t,
                        input byte_t exp);
    u_nvm_programmer.read(s, t, rd);
    check(w, exp, rd);
  endtask
  task automatic erase();
    cmd(`CMD_ERASE);
    wr(1'b0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    rstn_i = 1'b0;
    repeat (4) @(posedge clk_i);
    check("reset fuses", {`FUSE_LO_RST, `FUSE_HI_RST}, {lfuse, hfuse});
    check("reset flags", {`LOCK_CLEAR, 3'b110}, {lock, rdy, oe_n, pm});
    rstn_i <= 1'b1;
    u_nvm_programmer.enter(1'b1);
    check("jolted entry", 1'b0, pm);
    u_nvm_programmer.enter(1'b0);
    check("entry", 1'b1, pm);
    erase();
    cmd(`CMD_WEEP);
    foreach (rows[i]) begin
      addr(rows[i].ahi, rows[i].alo);
      ld_b(`ACT_DATA, 1'b0, rows[i].val);
      wr(1'b0);
    end
    cmd(`CMD_REEP);
    foreach (rows[i]) begin
      addr(rows[i].ahi, rows[i].alo);
      rd_chk("eeprom byte", 1'b0, 1'b0, rows[i].val);
    end
    ld_b(2'b11, 1'b0, `CMD_NOP);
    rd_chk("idle code", 1'b0, 1'b0, rows[3].val);
    cmd(`CMD_WFLASH);
    for (int w = 0; w < `PAGE_WORDS; w++) begin
      ld_b(`ACT_ADDR, 1'b0, {2'b11, 6'(w)});
      ld_b(`ACT_DATA, 1'b0, 8'(w) ^ 8'h5a);
      u_nvm_programmer.latch(1'b0);
      ld_b(`ACT_DATA, 1'b1, 8'(w) + 8'h80);
      u_nvm_programmer.latch(1'b1);
    end
    ld_b(`ACT_ADDR, 1'b1, 8'h1f);
    wr(1'b0);
    cmd(`CMD_NOP);
    cmd(`CMD_RFLASH);
    for (int w = 0; w < `PAGE_WORDS; w += 63) begin
      addr(8'h1f, {2'b11, 6'(w)});
      rd_chk("flash low", 1'b0, 1'b0, 8'(w) ^ 8'h5a);
      rd_chk("flash high", 1'b1, 1'b0, 8'(w) + 8'h80);
    end
    addr(8'h1f, 8'h80);
    rd_chk("other page", 1'b0, 1'b0, `ERASED_BYTE);
    cmd(`CMD_WFUSE);
    ld_b(`ACT_DATA, 1'b0, 8'h51);
    wr(1'b0);
    ld_b(`ACT_DATA, 1'b0, 8'hf9);
    wr(1'b1);
    check("fuses", 16'h51f9, {lfuse, hfuse});
    cmd(`CMD_RFUSE);
    rd_chk("high fuse read", 1'b1, 1'b1, 8'hf9);
    cmd(`CMD_WLOCK);
    ld_b(`ACT_DATA, 1'b0, 8'hfa);
    wr(1'b0);
    ld_b(`ACT_DATA, 1'b0, 8'hff);
    wr(1'b0);
    check("lock bits", 6'h3a, lock);
    cmd(`CMD_RFUSE);
    rd_chk("lock read", 1'b1, 1'b0, 8'hfa);
    rd_chk("low fuse read", 1'b0, 1'b0, 8'h51);
    cmd(`CMD_WFUSE);
    ld_b(`ACT_DATA, 1'b0, 8'hff);
    u_nvm_programmer.write(1'b0);
    wait_ready();
    check("locked fuses", 8'h51, lfuse);
    erase();
    check("after erase", 24'h51f93f, {lfuse, hfuse, 2'b00, lock});
    cmd(`CMD_REEP);
    addr(8'h00, 8'h00);
    rd_chk("erased eeprom", 1'b0, 1'b0, `ERASED_BYTE);
    @(posedge clk_i);
    check("bus released", 1'b1, oe_n);
    final_report();
  end
endmodule
